//--- include/smsa_pkg.sv
// Package of constants and types for the stepper motion-state arbiter
package smsa_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam longint CLK_HZ = 125000000;
	localparam longint UV_HOLD_S = 15;
	localparam int unsigned UV_HOLD_CYCLES = int'(UV_HOLD_S * CLK_HZ);

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] REG_CONFIG = 8'h00;
	localparam logic [7:0] REG_SECPOS = 8'h04;
	localparam logic [7:0] REG_STATE = 8'h08;
	localparam logic [7:0] REG_POSITION = 8'h0C;
	localparam logic [7:0] REG_PARAM = 8'h10;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CFG_SLEEP_ALLOW_BIT = 0;
	localparam int STATE_FLAGS_LSB = 16;
	localparam int PARAM_VMIN_LSB = 4;
	localparam int PARAM_ACC_BIT = 8;
	localparam logic [10:0] SEC_DISABLED = 11'h400;
	localparam logic RST_SLEEP_ALLOW = 1'b1;
	localparam logic [3:0] RST_VMAX = 4'h0;
	localparam logic [3:0] RST_VMIN = 4'h0;
	localparam logic RST_ACC_SHAPE = 1'b0;

	// ----------------------------------------
	// Bus command codes
	// ----------------------------------------
	localparam logic [3:0] CMD_NONE = 4'h0;
	localparam logic [3:0] CMD_POS = 4'h1;
	localparam logic [3:0] CMD_POS_SHORT = 4'h2;
	localparam logic [3:0] CMD_SAFE_GO = 4'h3;
	localparam logic [3:0] CMD_DUAL = 4'h4;
	localparam logic [3:0] CMD_RAMP_HALT = 4'h5;
	localparam logic [3:0] CMD_SLEEP = 4'h6;
	localparam logic [3:0] CMD_ABRUPT_HALT = 4'h7;
	localparam logic [3:0] CMD_PARAM = 4'h8;
	localparam logic [3:0] CMD_STATUS = 4'h9;
	localparam logic [3:0] CMD_FULL_STATUS = 4'hA;
	localparam logic [3:0] CMD_ID_ASSIGN = 4'hB;

	// ----------------------------------------
	// Motion states
	// ----------------------------------------
	typedef enum logic [10:0] {
		ST_STANDBY = 11'h001,
		ST_STOPPED = 11'h002,
		ST_MOVING = 11'h004,
		ST_DUAL = 11'h008,
		ST_RAMP_HALT = 11'h010,
		ST_ABRUPT_HALT = 11'h020,
		ST_HALTED_RAMP = 11'h040,
		ST_SHUTDOWN = 11'h080,
		ST_SLEEP = 11'h100,
		ST_UV_HALT = 11'h200,
		ST_UV_OFF = 11'h400
	} smsa_state_t;

endpackage

//--- include/smsa_uv_if.sv
// Interface between the arbiter and its undervoltage hold timer
`timescale 1ns/10ps
interface smsa_uv_if;
	logic lowVolt;
	logic expired;
	modport timer (input lowVolt, output expired);
	modport user (output lowVolt, input expired);
endinterface

//--- src/smsa_arbiter.sv
// Motion-state arbiter of a bus-controlled stepper positioner
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
module smsa_arbiter #(
	parameter int unsigned UV_HOLD_CYCLES = smsa_pkg::UV_HOLD_CYCLES
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic cmdValid,
	input wire logic [3:0] cmdCode,
	input wire logic [15:0] cmdPos,
	input wire logic [15:0] cmdPos2,
	input wire logic [3:0] cmdVmax,
	input wire logic [3:0] cmdVmin,
	input wire logic cmdAcc,
	input wire logic cmdHasVmax,
	input wire logic cmdHasVmin,
	input wire logic cmdHasAcc,
	input wire logic busTimeout,
	input wire logic wakeUp,
	input wire logic thermalShutdown,
	input wire logic underVolt2,
	input wire logic coilDefect,
	input wire logic motionDone,
	input wire logic [15:0] actPos,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata,
	output smsa_pkg::smsa_state_t motionState,
	output logic [15:0] targetPos,
	output logic [15:0] motionTarget,
	output logic [3:0] activeVmax,
	output logic [3:0] activeVmin,
	output logic rampProfileSelect,
	output logic moveStart,
	output logic rampHaltReq,
	output logic abruptHaltReq,
	output logic bridgeHiZ,
	output logic powerDown,
	output logic idAssignAck,
	output logic [31:0] statusWord,
	output logic abruptHaltFlag,
	output logic stepLoss
);
	import smsa_pkg::*;

	typedef struct packed {
		smsa_state_t st;
		logic [15:0] tagPos;
		logic [10:0] secPos;
		logic sleepAllow;
		logic sleepReq;
		logic stopFlag;
		logic dualStage;
		logic tsdF;
		logic uv2F;
		logic elDefF;
		logic hsF;
		logic stepLoss;
		logic seen;
		logic [3:0] vmax;
		logic [3:0] vmin;
		logic ramp_profile_select;
		logic [3:0] dVmax;
		logic [3:0] dVmin;
		logic dAcc;
		logic [15:0] dPos1;
		logic [15:0] dPos2;
		logic [15:0] motionTarget;
		logic [3:0] outVmax;
		logic [3:0] outVmin;
		logic outAcc;
		logic moveStart;
		logic rampHalt;
		logic abruptHalt;
		logic hiZ;
		logic powerDown;
		logic idAck;
		logic [31:0] rdata;
		logic [31:0] statusWord;
	} smsa_regs_t;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic smsa_regs_t resetValue();
		smsa_regs_t v;
		v = '0;
		v.st = ST_STANDBY;
		v.secPos = SEC_DISABLED;
		v.sleepAllow = RST_SLEEP_ALLOW;
		v.vmax = RST_VMAX;
		v.vmin = RST_VMIN;
		v.ramp_profile_select = RST_ACC_SHAPE;
		v.outVmax = RST_VMAX;
		v.outVmin = RST_VMIN;
		v.outAcc = RST_ACC_SHAPE;
		return v;
	endfunction

	function automatic logic secureEnable(input logic [10:0] pos);
		return pos != SEC_DISABLED;
	endfunction

	function automatic logic [15:0] secWide(input logic [10:0] pos);
		return {{5{pos[10]}}, pos};
	endfunction

	function automatic logic isPosCmd(input logic [3:0] c);
		return (c == CMD_POS) || (c == CMD_POS_SHORT);
	endfunction

	function automatic logic isStatusCmd(input logic [3:0] c);
		return (c == CMD_STATUS) || (c == CMD_FULL_STATUS);
	endfunction

	localparam smsa_regs_t RST = resetValue();

	smsa_regs_t r;
	smsa_regs_t next_r;
	logic [3:0] cmd;
	logic uvLong;
	logic secure_enable;
	logic faultsGone;

	smsa_uv_if uvIf ();

	smsa_uv_timer #(
		.HOLD_CYCLES(UV_HOLD_CYCLES)
	) uvTimer (
		.core_clk(core_clk),
		.rstn(rstn),
		.uv(uvIf.timer)
	);

	assign uvIf.lowVolt = underVolt2;
	assign uvLong = uvIf.expired;
	assign cmd = (cmdValid && (r.st != ST_SLEEP)) ? cmdCode : CMD_NONE;
	assign secure_enable = secureEnable(r.secPos);
	assign faultsGone = !thermalShutdown && !underVolt2 && !coilDefect;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		next_r = r;
		next_r.moveStart = 1'b0;
		next_r.idAck = 1'b0;
		next_r.rdata = '0;

		if (cmd != CMD_NONE) begin
			next_r.sleepReq = 1'b0;
		end
		if (busTimeout || (cmd == CMD_SLEEP)) begin
			next_r.sleepReq = 1'b1;
		end

		// Working RAM only; a running two-stage move keeps its copy
		if (cmd == CMD_PARAM) begin
			next_r.vmax = cmdVmax;
			next_r.vmin = cmdVmin;
			next_r.ramp_profile_select = cmdAcc;
		end

		if (isStatusCmd(cmd)) begin
			next_r.stepLoss = 1'b0;
		end
		if (cmd == CMD_FULL_STATUS) begin
			next_r.seen = 1'b1;
			next_r.statusWord = {r.vmax, r.vmin, 2'h0, r.stepLoss, r.hsF, r.elDefF, r.uv2F,
				r.tsdF, r.sleepReq, 5'h00, r.st};
		end
		// Clear only after seen and with causes gone
		if (isStatusCmd(cmd) && r.seen && faultsGone && !uvLong) begin
			next_r.tsdF = 1'b0;
			next_r.uv2F = 1'b0;
			next_r.elDefF = 1'b0;
			next_r.hsF = 1'b0;
			next_r.seen = 1'b0;
		end
		// Hardware sets win over a same-cycle clear
		// A fresh fault needs a fresh full read
		if (thermalShutdown) begin
			next_r.tsdF = 1'b1;
			next_r.seen = 1'b0;
		end
		if (uvLong) begin
			next_r.uv2F = 1'b1;
			next_r.seen = 1'b0;
		end
		if (coilDefect) begin
			next_r.elDefF = 1'b1;
			next_r.hsF = 1'b1;
			next_r.seen = 1'b0;
		end

		if (cmd == CMD_ID_ASSIGN) begin
			next_r.idAck = 1'b1;
		end

		if (regWr && (r.st != ST_SLEEP)) begin
			case (regAddr)
				REG_CONFIG: begin
					next_r.sleepAllow = regWdata[CFG_SLEEP_ALLOW_BIT];
				end
				REG_SECPOS: begin
					next_r.secPos = regWdata[10:0];
				end
				default: begin
				end
			endcase
		end
		if (regRd) begin
			case (regAddr)
				REG_CONFIG: next_r.rdata = {31'h00000000, r.sleepAllow};
				REG_SECPOS: next_r.rdata = {21'h000000, r.secPos};
				REG_STATE: next_r.rdata = {8'h00, r.seen, r.stepLoss, r.hsF, r.elDefF, r.uv2F,
					r.tsdF, r.stopFlag, r.sleepReq, 5'h00, r.st};
				REG_POSITION: next_r.rdata = {r.tagPos, actPos};
				REG_PARAM: next_r.rdata = {23'h000000, r.ramp_profile_select, r.vmin, r.vmax};
				default: next_r.rdata = '0;
			endcase
		end

		// Unlisted commands fall through each state untouched
		case (r.st)
			ST_STANDBY: begin
				if (r.sleepReq) begin
					next_r.st = ST_SLEEP;
				end else begin
					next_r.st = ST_STOPPED;
				end
			end
			ST_STOPPED: begin
				// Stop flag lasts one stopped cycle
				next_r.stopFlag = 1'b0;
				if (thermalShutdown || coilDefect) begin
					next_r.st = ST_SHUTDOWN;
					next_r.tagPos = actPos;
				end else if (uvLong) begin
					next_r.st = ST_UV_HALT;
				end else if (r.sleepReq && r.sleepAllow) begin
					// Sleep or head for safe position
					if (!secure_enable || (actPos == secWide(r.secPos)) || r.stopFlag) begin
						next_r.st = ST_SLEEP;
					end else begin
						next_r.tagPos = secWide(r.secPos);
						next_r.st = ST_MOVING;
						next_r.moveStart = 1'b1;
					end
				// Step loss does not block position commands
				end else if (isPosCmd(cmd)) begin
					next_r.tagPos = cmdPos;
					next_r.st = ST_MOVING;
					next_r.moveStart = 1'b1;
				end else if ((cmd == CMD_SAFE_GO) && secure_enable) begin
					next_r.tagPos = secWide(r.secPos);
					next_r.st = ST_MOVING;
					next_r.moveStart = 1'b1;
				end else if (cmd == CMD_DUAL) begin
					// Private copy, gaps filled from working RAM
					next_r.dVmax = cmdHasVmax ? cmdVmax : r.vmax;
					next_r.dVmin = cmdHasVmin ? cmdVmin : r.vmin;
					next_r.dAcc = cmdHasAcc ? cmdAcc : r.ramp_profile_select;
					next_r.dPos1 = cmdPos;
					next_r.dPos2 = cmdPos2;
					next_r.dualStage = 1'b0;
					next_r.st = ST_DUAL;
					next_r.moveStart = 1'b1;
				end else if (r.tagPos != actPos) begin
					next_r.st = ST_MOVING;
					next_r.moveStart = 1'b1;
				end
			end
			ST_MOVING: begin
				if (coilDefect) begin
					next_r.st = ST_ABRUPT_HALT;
					next_r.stepLoss = 1'b1;
				end else if (thermalShutdown) begin
					next_r.st = ST_RAMP_HALT;
				end else if (uvLong) begin
					next_r.st = ST_UV_HALT;
				end else if (cmd == CMD_ABRUPT_HALT) begin
					next_r.st = ST_ABRUPT_HALT;
				end else if (motionDone) begin
					next_r.st = ST_STOPPED;
				end else if (r.sleepReq) begin
					// Sleep via ramped halt unless a safe target exists
					if (secure_enable) begin
						next_r.tagPos = secWide(r.secPos);
					end else begin
						next_r.st = ST_RAMP_HALT;
					end
				end else if (cmd == CMD_RAMP_HALT) begin
					next_r.st = ST_RAMP_HALT;
				end else if (isPosCmd(cmd)) begin
					next_r.tagPos = cmdPos;
				end else if ((cmd == CMD_SAFE_GO) && secure_enable) begin
					next_r.tagPos = secWide(r.secPos);
				end
			end
			// Target untouched here; working RAM still takes CMD_PARAM
			ST_DUAL: begin
				if (coilDefect) begin
					next_r.st = ST_ABRUPT_HALT;
					next_r.stepLoss = 1'b1;
				end else if (thermalShutdown) begin
					next_r.st = ST_RAMP_HALT;
				end else if (uvLong || (cmd == CMD_ABRUPT_HALT)) begin
					next_r.st = ST_ABRUPT_HALT;
				end else if (motionDone) begin
					if (!r.dualStage) begin
						next_r.dualStage = 1'b1;
						next_r.moveStart = 1'b1;
					end else begin
						next_r.st = ST_STOPPED;
						next_r.dualStage = 1'b0;
					end
				end
			end
			ST_RAMP_HALT: begin
				if (coilDefect) begin
					next_r.st = ST_ABRUPT_HALT;
					next_r.stepLoss = 1'b1;
				end else if (uvLong) begin
					next_r.st = ST_UV_HALT;
				end else if (cmd == CMD_ABRUPT_HALT) begin
					next_r.st = ST_ABRUPT_HALT;
				end else if (motionDone) begin
					next_r.stopFlag = 1'b1;
					next_r.tagPos = actPos;
					next_r.dualStage = 1'b0;
					next_r.st = (r.tsdF || thermalShutdown) ? ST_HALTED_RAMP : ST_STOPPED;
				end
			end
			ST_ABRUPT_HALT: begin
				if (motionDone) begin
					next_r.stopFlag = 1'b1;
					next_r.tagPos = actPos;
					next_r.dualStage = 1'b0;
					next_r.st = ST_STOPPED;
				end
			end
			ST_HALTED_RAMP: begin
				if (r.tsdF || thermalShutdown) begin
					next_r.st = ST_SHUTDOWN;
					next_r.tagPos = actPos;
				end else begin
					next_r.st = ST_STOPPED;
				end
			end
			ST_SHUTDOWN: begin
				if (busTimeout) begin
					next_r.st = ST_SLEEP;
				// Exit once both flags are clear
				end else if (!r.tsdF && !r.hsF) begin
					next_r.st = ST_STOPPED;
				end
			end
			ST_UV_HALT: begin
				if (motionDone) begin
					next_r.st = ST_UV_OFF;
				end
			end
			ST_UV_OFF: begin
				// No position copy from autonomous states
				if (thermalShutdown || coilDefect) begin
					next_r.st = ST_SHUTDOWN;
				end else if (!underVolt2 && !uvLong) begin
					next_r.st = ST_STOPPED;
				end
			end
			ST_SLEEP: begin
			end
			default: begin
				next_r.st = ST_STANDBY;
			end
		endcase

		if ((r.st == ST_SLEEP) && wakeUp) begin
			next_r = RST;
		end

		// Outputs follow the state being entered
		next_r.hiZ = (next_r.st == ST_SHUTDOWN) || (next_r.st == ST_SLEEP) ||
			(next_r.st == ST_UV_OFF);
		next_r.powerDown = next_r.st == ST_SLEEP;
		next_r.rampHalt = next_r.st == ST_RAMP_HALT;
		next_r.abruptHalt = (next_r.st == ST_ABRUPT_HALT) || (next_r.st == ST_UV_HALT);
		if (next_r.st == ST_DUAL) begin
			// Private set, ramp profile forced in second motion
			next_r.motionTarget = next_r.dualStage ? next_r.dPos2 : next_r.dPos1;
			next_r.outVmax = next_r.dVmax;
			next_r.outVmin = next_r.dVmin;
			next_r.outAcc = next_r.dualStage ? 1'b1 : next_r.dAcc;
		end else begin
			next_r.motionTarget = next_r.tagPos;
			next_r.outVmax = next_r.vmax;
			next_r.outVmin = next_r.vmin;
			next_r.outAcc = next_r.ramp_profile_select;
		end
	end

	// Single register stage keeps every output glitch free
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			r <= RST;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign regRdata = r.rdata;
	assign motionState = r.st;
	assign targetPos = r.tagPos;
	assign motionTarget = r.motionTarget;
	assign activeVmax = r.outVmax;
	assign activeVmin = r.outVmin;
	assign rampProfileSelect = r.outAcc;
	assign moveStart = r.moveStart;
	assign rampHaltReq = r.rampHalt;
	assign abruptHaltReq = r.abruptHalt;
	assign bridgeHiZ = r.hiZ;
	assign powerDown = r.powerDown;
	assign idAssignAck = r.idAck;
	assign statusWord = r.statusWord;
	assign abruptHaltFlag = r.hsF;
	assign stepLoss = r.stepLoss;
endmodule

//--- src/smsa_uv_timer.sv
// Undervoltage duration timer for the motion-state arbiter
`timescale 1ns/10ps
module smsa_uv_timer #(
	parameter int unsigned HOLD_CYCLES = smsa_pkg::UV_HOLD_CYCLES
) (
	input wire logic core_clk,
	input wire logic rstn,
	smsa_uv_if.timer uv
);
	import smsa_pkg::*;

	typedef struct packed {
		logic [30:0] cnt;
		logic expired;
	} smsa_uv_regs_t;

	localparam logic [30:0] LAST = 31'(HOLD_CYCLES - 1);

	smsa_uv_regs_t r;
	smsa_uv_regs_t next_r;

	// ----------------------------------------
	// Counting
	// ----------------------------------------
	always_comb begin
		next_r = r;
		// Any recovery restarts the full hold time
		if (!uv.lowVolt) begin
			next_r.cnt = '0;
			next_r.expired = 1'b0;
		end else if (r.cnt >= LAST) begin
			next_r.expired = 1'b1;
		end else begin
			next_r.cnt = r.cnt + 31'h00000001;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign uv.expired = r.expired;
endmodule

//--- verif/smsa_arbiter_asserts.sv
// Port-level assertion checker for the motion-state arbiter
`timescale 1ns/10ps
module smsa_arbiter_asserts #(
	parameter int unsigned UV_HOLD_CYCLES = 20
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic cmdValid,
	input wire logic [3:0] cmdCode,
	input wire logic thermalShutdown,
	input wire logic underVolt2,
	input wire logic coilDefect,
	input wire logic motionDone,
	input wire logic [15:0] actPos,
	input wire logic [7:0] regAddr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire smsa_pkg::smsa_state_t motionState,
	input wire logic [15:0] targetPos,
	input wire logic moveStart,
	input wire logic rampProfileSelect,
	input wire logic bridgeHiZ,
	input wire logic powerDown,
	input wire logic idAssignAck,
	input wire logic abruptHaltFlag,
	input wire logic stepLoss
);
	import smsa_pkg::*;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	std_after_rst_a: assert property ($rose(rstn) |-> motionState == ST_STANDBY)
		else $error("state not standby after reset");
	shut_hiz_a: assert property (motionState == ST_SHUTDOWN |-> bridgeHiZ && !powerDown)
		else $error("bridges driven in shutdown");
	shut_copy_a: assert property ($changed(motionState) && motionState == ST_SHUTDOWN &&
		$past(motionState) != ST_UV_OFF |-> targetPos == $past(actPos))
		else $error("target not copied on shutdown");
	sleep_entry_a: assert property ($changed(motionState) && motionState == ST_SLEEP |->
		powerDown && $past(motionState) inside {ST_STANDBY, ST_STOPPED, ST_SHUTDOWN, ST_UV_OFF})
		else $error("sleep entered from motion");
	id_ack_a: assert property (cmdValid && cmdCode == CMD_ID_ASSIGN &&
		motionState != ST_SLEEP |=> idAssignAck)
		else $error("id assign not acknowledged");
	sleep_deaf_a: assert property (cmdValid && motionState == ST_SLEEP |=>
		!idAssignAck && !moveStart)
		else $error("command acted on in sleep");
	halt_done_a: assert property (motionDone && motionState == ST_ABRUPT_HALT |=>
		motionState == ST_STOPPED && targetPos == $past(actPos))
		else $error("abrupt halt did not settle");
	therm_move_a: assert property (thermalShutdown && motionState == ST_MOVING && !motionDone &&
		!coilDefect && !underVolt2 && !cmdValid |=> motionState == ST_RAMP_HALT)
		else $error("thermal did not ramp halt");
	coil_move_a: assert property (coilDefect && motionState == ST_MOVING && !motionDone &&
		!thermalShutdown && !cmdValid |=> motionState == ST_ABRUPT_HALT && stepLoss && abruptHaltFlag)
		else $error("coil defect not handled");
	dual_shape_a: assert property (motionState == ST_DUAL && moveStart &&
		$past(motionState) == ST_DUAL |-> rampProfileSelect)
		else $error("second stage profile not forced");
	dual_keep_a: assert property (motionState == ST_DUAL |-> targetPos == $past(targetPos))
		else $error("target changed in two-stage move");
	unmapped_rd_a: assert property (regRd && regAddr > REG_PARAM |=> regRdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind smsa_arbiter smsa_arbiter_asserts #(.UV_HOLD_CYCLES(UV_HOLD_CYCLES)) chk (
	.core_clk, .rstn, .cmdValid, .cmdCode, .thermalShutdown, .underVolt2, .coilDefect,
	.motionDone, .actPos, .regAddr, .regRd, .regRdata, .motionState, .targetPos, .moveStart,
	.rampProfileSelect, .bridgeHiZ, .powerDown, .idAssignAck, .abruptHaltFlag, .stepLoss
);

//--- verif/smsa_arbiter_tb.sv
// Self-checking bench for the motion-state arbiter
`timescale 1ns/10ps
module smsa_arbiter_tb;
	import smsa_pkg::*;
	logic core_clk, rstn, busTimeout, wakeUp, thermalShutdown, coilDefect, motionDone, underVolt2;
	logic regWr, regRd, cmdValid, cmdAcc, rampProfileSelect, moveStart, rampHaltReq;
	logic abruptHaltReq, bridgeHiZ, powerDown, idAssignAck, abruptHaltFlag, stepLoss;
	logic [15:0] actPos, cmdPos, cmdPos2, targetPos, motionTarget;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata, statusWord, rd;
	logic [3:0] cmdCode, cmdVmax, cmdVmin, activeVmax, activeVmin;
	logic [2:0] cmdHas;
	smsa_state_t motionState;
	int numErrors = 0;
	int cmpCount = 0;
	int cycles = 0;
	smsa_lin_master lin (.core_clk, .motionState, .cmdValid, .cmdCode, .cmdPos, .cmdPos2,
		.cmdVmax, .cmdVmin, .cmdAcc, .cmdHas);
	smsa_arbiter #(.UV_HOLD_CYCLES(20)) dut (
		.core_clk, .rstn, .cmdValid, .cmdCode, .cmdPos, .cmdPos2, .cmdVmax, .cmdVmin, .cmdAcc,
		.cmdHasVmax(cmdHas[2]), .cmdHasVmin(cmdHas[1]), .cmdHasAcc(cmdHas[0]),
		.busTimeout, .wakeUp, .thermalShutdown, .underVolt2, .coilDefect, .motionDone,
		.actPos, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .motionState, .targetPos,
		.motionTarget, .activeVmax, .activeVmin, .rampProfileSelect, .moveStart, .rampHaltReq,
		.abruptHaltReq, .bridgeHiZ, .powerDown, .idAssignAck, .statusWord, .abruptHaltFlag,
		.stepLoss);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic printVerdict;
		$display("comparisons %0d mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic waitState(input smsa_state_t s, input string what);
		int n = 0;
		while (motionState !== s && n < 8) begin
			@(negedge core_clk);
			n++;
		end
		check(what, motionState, s);
	endtask
	task automatic cmd(input logic [3:0] code, input logic [15:0] p);
		lin.send(code, p, 16'h0, 9'h0, 3'h0);
		@(negedge core_clk);
	endtask
	task automatic done;
		@(posedge core_clk);
		motionDone <= 1'h1;
		@(posedge core_clk);
		motionDone <= 1'h0;
		@(negedge core_clk);
	endtask
	task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regWr <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'h0;
	endtask
	task automatic regRead(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regRd <= 1'h1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'h0;
		@(negedge core_clk);
		d = regRdata;
	endtask
	task automatic wake;
		@(posedge core_clk);
		actPos <= 16'h0;
		wakeUp <= 1'h1;
		@(posedge core_clk);
		wakeUp <= 1'h0;
		repeat (3) @(negedge core_clk);
		check("wake state", motionState, ST_STOPPED);
		check("wake target", targetPos, 16'h0);
		check("wake status", statusWord, 32'h0);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic tMove;
		cmd(CMD_RAMP_HALT, 16'h0);
		check("ignored halt", motionState, ST_STOPPED);
		cmd(CMD_POS, 16'h0040);
		check("move target", motionTarget, 16'h0040);
		check("move start", moveStart, 1'h1);
		@(posedge core_clk);
		actPos <= 16'h0040;
		done();
		check("move end", motionState, ST_STOPPED);
		@(posedge core_clk);
		actPos <= 16'h0050;
		waitState(ST_MOVING, "drift move");
		cmd(CMD_RAMP_HALT, 16'h0);
		check("ramp req", rampHaltReq, 1'h1);
		done();
		check("halt end", motionState, ST_STOPPED);
		check("halt copy", targetPos, 16'h0050);
	endtask
	task automatic tSleep;
		regWrite(REG_CONFIG, 32'h0);
		cmd(CMD_FULL_STATUS, 16'h0);
		@(posedge core_clk);
		busTimeout <= 1'h1;
		@(posedge core_clk);
		busTimeout <= 1'h0;
		repeat (3) @(negedge core_clk);
		check("no sleep", motionState, ST_STOPPED);
		regRead(REG_STATE, rd);
		check("sleep flag", rd[16], 1'h1);
		cmd(CMD_ID_ASSIGN, 16'h0);
		check("id ack", idAssignAck, 1'h1);
		regRead(REG_STATE, rd);
		check("sleep cancel", rd[16], 1'h0);
		regWrite(REG_CONFIG, 32'h1);
		cmd(CMD_SLEEP, 16'h0);
		waitState(ST_SLEEP, "unsecured sleep");
		cmd(CMD_ID_ASSIGN, 16'h0);
		check("asleep ack", idAssignAck, 1'h0);
		wake();
		regRead(8'h20, rd);
		check("unmapped", rd, 32'h0);
	endtask
	task automatic tSecure;
		regWrite(REG_SECPOS, 32'h10);
		cmd(CMD_SLEEP, 16'h0);
		waitState(ST_MOVING, "secure move");
		check("secure target", targetPos, 16'h0010);
		@(posedge core_clk);
		actPos <= 16'h0010;
		done();
		waitState(ST_SLEEP, "secure sleep");
		wake();
		regRead(REG_SECPOS, rd);
		check("secpos reset", rd, 32'h400);
	endtask
	task automatic tThermal;
		cmd(CMD_POS, 16'h0008);
		@(posedge core_clk);
		thermalShutdown <= 1'h1;
		actPos <= 16'h0004;
		repeat (2) @(negedge core_clk);
		check("therm halt", motionState, ST_RAMP_HALT);
		done();
		waitState(ST_SHUTDOWN, "therm shut");
		check("shut target", targetPos, 16'h0004);
		check("shut hiz", bridgeHiZ, 1'h1);
		@(posedge core_clk);
		thermalShutdown <= 1'h0;
		cmd(CMD_STATUS, 16'h0);
		check("unread clear", motionState, ST_SHUTDOWN);
		cmd(CMD_FULL_STATUS, 16'h0);
		check("flag held", motionState, ST_SHUTDOWN);
		cmd(CMD_STATUS, 16'h0);
		waitState(ST_STOPPED, "shut exit");
	endtask
	task automatic tDual;
		lin.send(CMD_DUAL, 16'h0020, 16'h0030, 9'h005, 3'h4);
		@(negedge core_clk);
		check("dual target", targetPos, 16'h0004);
		check("dual pos", motionTarget, 16'h0020);
		check("dual vmax", activeVmax, 4'h5);
		check("dual vmin", activeVmin, RST_VMIN);
		lin.send(CMD_PARAM, 16'h0, 16'h0, 9'h029, 3'h0);
		@(negedge core_clk);
		check("param late", activeVmax, 4'h5);
		cmd(CMD_FULL_STATUS, 16'h0);
		check("ram speeds", statusWord[31:24], 8'h92);
		done();
		check("stage two", motionTarget, 16'h0030);
		check("stage shape", rampProfileSelect, 1'h1);
		done();
		check("dual end", motionState, ST_STOPPED);
		cmd(CMD_POS, 16'h0004);
		check("param used", activeVmax, 4'h9);
		done();
	endtask
	task automatic tCoil;
		cmd(CMD_POS, 16'h0010);
		@(posedge core_clk);
		coilDefect <= 1'h1;
		repeat (2) @(negedge core_clk);
		check("coil halt", motionState, ST_ABRUPT_HALT);
		check("coil req", abruptHaltReq, 1'h1);
		check("coil loss", stepLoss, 1'h1);
		@(posedge core_clk);
		coilDefect <= 1'h0;
		actPos <= 16'h0009;
		done();
		check("coil copy", targetPos, 16'h0009);
		cmd(CMD_POS, 16'h000C);
		check("lossy move", motionState, ST_MOVING);
		@(posedge core_clk);
		actPos <= 16'h000C;
		done();
		cmd(CMD_STATUS, 16'h0);
		check("loss clear", stepLoss, 1'h0);
		check("halt flag unread", abruptHaltFlag, 1'h1);
		cmd(CMD_FULL_STATUS, 16'h0);
		cmd(CMD_STATUS, 16'h0);
		check("halt flag clear", abruptHaltFlag, 1'h0);
	endtask
	task automatic tUnder;
		@(posedge core_clk);
		underVolt2 <= 1'h1;
		repeat (24) @(negedge core_clk);
		check("uv halt", motionState, ST_UV_HALT);
		done();
		check("uv off", bridgeHiZ, 1'h1);
		@(posedge core_clk);
		underVolt2 <= 1'h0;
		waitState(ST_STOPPED, "uv exit");
	endtask
	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			numErrors++;
			printVerdict();
		end
	end
	initial begin
		rstn = 1'h0;
		{busTimeout, wakeUp, thermalShutdown, coilDefect, motionDone, regWr, regRd, underVolt2} = 8'h0;
		actPos = 16'h0;
		regAddr = 8'h0;
		regWdata = 32'h0;
		repeat (6) @(posedge core_clk);
		check("reset state", motionState, ST_STANDBY);
		rstn <= 1'h1;
		waitState(ST_STOPPED, "boot");
		tMove();
		tSleep();
		tSecure();
		tThermal();
		tDual();
		tCoil();
		tUnder();
		printVerdict();
	end
endmodule

//--- verif/smsa_lin_master.sv
// Bus master model that issues commands to the motion-state arbiter
`timescale 1ns/10ps
module smsa_lin_master (
	input wire logic core_clk,
	input wire smsa_pkg::smsa_state_t motionState,
	output logic cmdValid,
	output logic [3:0] cmdCode,
	output logic [15:0] cmdPos,
	output logic [15:0] cmdPos2,
	output logic [3:0] cmdVmax,
	output logic [3:0] cmdVmin,
	output logic cmdAcc,
	output logic [2:0] cmdHas
);
	import smsa_pkg::*;
	initial begin
		cmdValid = 1'h0;
		cmdCode = CMD_NONE;
		cmdPos = 16'h0;
		cmdPos2 = 16'h0;
		{cmdAcc, cmdVmin, cmdVmax} = 9'h0;
		cmdHas = 3'h0;
	end
	// ----------------------------------------
	// One command frame
	// ----------------------------------------
	task automatic send(input logic [3:0] code, input logic [15:0] p, input logic [15:0] p2,
		input logic [8:0] par, input logic [2:0] has);
		@(posedge core_clk);
		if (!(code == CMD_PARAM && motionState == ST_MOVING)) begin
			cmdValid <= 1'h1;
			cmdCode <= code;
			cmdPos <= p;
			cmdPos2 <= p2;
			{cmdAcc, cmdVmin, cmdVmax} <= par;
			cmdHas <= has;
			@(posedge core_clk);
			cmdValid <= 1'h0;
			cmdCode <= CMD_NONE;
			// Released position fields show their inverse, not the last value
			cmdPos <= ~p;
			cmdPos2 <= ~p2;
		end
	endtask
endmodule
